/* bench/eba_cpu.sv */
`timescale 1ns/1ps
module eba_cpu
    import eba_pkg::*;
(
    input  wire logic       clk,
    output      logic [5:0] io_addr,
    output      logic       io_we,
    output      logic       io_re,
    output      logic [7:0] io_wdata
);
    // ====================================================================
    // Bus cycles
    // Released address and data lines show the inverse of their last value and both strobes drop low, so no stale match.
    initial begin
        io_addr = 6'h00;
        io_we = 1'b0;
        io_re = 1'b0;
        io_wdata = 8'h00;
    end

    task automatic io_cycle(input logic [5:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_we = w;
        io_re = ~w;
        @(posedge clk);
        #1;
        io_we = 1'b0;
        io_re = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask

    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        io_cycle(a, d, 1'b1);
    endtask

    task automatic io_read(input logic [5:0] a);
        io_cycle(a, 8'h00, 1'b0);
    endtask

    // ====================================================================
    // Software sequences
    task automatic set_addr(input logic [8:0] a);
        io_write(EBA_OFS_ADDR_HIGH, {7'h00, a[8]});
        io_write(EBA_OFS_ADDR_LOW, a[7:0]);
    endtask

    // A gap above two cycles lets the arm window lapse, as a slow CPU would.
    task automatic start_write(input logic [1:0] mode, input int gap);
        io_write(EBA_OFS_CTRL, {2'h0, mode, 4'h4});
        repeat (gap) @(posedge clk);
        io_write(EBA_OFS_CTRL, {2'h0, mode, 4'h2});
    endtask
endmodule

/* bench/eba_top_tb.sv */
`timescale 1ns/1ps
module eba_top_tb
    import eba_pkg::*;
;
    localparam int AT = 20;
    localparam int SP = 10;
    logic       clk;
    logic       rst;
    logic [5:0] io_addr;
    logic       io_we;
    logic       io_re;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       cpu_stall;
    logic       busy;
    logic       ready_pulse;
    logic       re_q;
    logic [7:0] exp_q[$];
    logic [31:0] rnd;
    logic [8:0] aa[3];
    logic [7:0] dd[3];
    int         fails;
    int         checks;

    eba_top #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) eba_top_i (
        .clk(clk), .rst(rst), .io_addr(io_addr), .io_we(io_we), .io_re(io_re),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
        .busy(busy), .ready_pulse(ready_pulse));
    eba_cpu eba_cpu_i (
        .clk(clk), .io_addr(io_addr), .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata));

    // ====================================================================
    // Checking
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_count(input string n, input int e, input int g);
        checks++;
        if (g != e) begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        eba_cpu_i.io_read(a);
    endtask

    // Counts stall, busy and a ready pulse that meets the busy fall.
    task automatic expect_timing(input int es, input int eb, input int er);
        int s;
        int b;
        int r;
        logic pb;
        s = 0;
        b = 0;
        r = 0;
        pb = 1'b0;
        for (int i = 0; i < 60; i++) begin
            s += (cpu_stall === 1'b1);
            b += (busy === 1'b1);
            r += (ready_pulse === 1'b1 && busy === 1'b0 && pb);
            pb = (busy === 1'b1);
            @(posedge clk);
            #1;
        end
        chk_count("cpu_stall cycles", es, s);
        chk_count("busy cycles", eb, b);
        chk_count("ready pulses", er, r);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) begin
            fails++;
            conclude();
        end
    endtask

    task automatic do_read();
        eba_cpu_i.io_write(EBA_OFS_CTRL, 8'h01);
        expect_timing(4, 0, 0);
    endtask

    always @(posedge clk) re_q <= io_re;
    always @(negedge clk) begin
        if (re_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[ERR] io_rdata expected none seen %h", io_rdata);
            end else begin
                chk_byte("io_rdata", exp_q.pop_front(), io_rdata);
            end
        end
    end

    // ====================================================================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        fails = 0;
        checks = 0;
        rnd = 32'hc379b74a;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(EBA_OFS_ADDR_HIGH, 8'h00);
        eba_cpu_i.io_write(EBA_OFS_ADDR_HIGH, 8'hff);
        rd(EBA_OFS_ADDR_HIGH, 8'h01);
        rd(6'h3f, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            aa[i] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : ({1'b0, rnd[15:8]} | 9'h001);
            dd[i] = rnd[7:0];
            eba_cpu_i.set_addr(aa[i]);
            rd(EBA_OFS_ADDR_LOW, aa[i][7:0]);
            eba_cpu_i.start_write(EBA_MODE_ERASE, 0);
            expect_timing(2, SP, 1);
            eba_cpu_i.io_write(EBA_OFS_DATA, dd[i]);
            eba_cpu_i.start_write(EBA_MODE_WRITE, 0);
            expect_timing(2, SP, 1);
            do_read();
            rd(EBA_OFS_DATA, dd[i]);
            eba_cpu_i.io_write(EBA_OFS_DATA, ~dd[i]);
            eba_cpu_i.start_write(EBA_MODE_ATOMIC, 0);
            expect_timing(2, AT, 1);
        end
        for (int i = 0; i < 3; i++) begin
            eba_cpu_i.set_addr(aa[i]);
            do_read();
            rd(EBA_OFS_DATA, ~dd[i]);
        end
        eba_cpu_i.io_write(EBA_OFS_CTRL, 8'h02);
        expect_timing(0, 0, 0);
        eba_cpu_i.start_write(EBA_MODE_ATOMIC, 5);
        expect_timing(0, 0, 0);
        eba_cpu_i.start_write(EBA_MODE_RSVD, 0);
        expect_timing(0, 0, 0);
        rd(EBA_OFS_CTRL, 8'h30);
        eba_cpu_i.io_write(EBA_OFS_CTRL, 8'h0c);
        rd(EBA_OFS_CTRL, 8'h0c);
        eba_cpu_i.set_addr(9'h000);
        eba_cpu_i.io_write(EBA_OFS_DATA, 8'h3c);
        eba_cpu_i.start_write(EBA_MODE_ATOMIC, 0);
        rd(EBA_OFS_CTRL, 8'h02);
        eba_cpu_i.io_write(EBA_OFS_ADDR_LOW, 8'h77);
        eba_cpu_i.io_write(EBA_OFS_ADDR_HIGH, 8'h01);
        eba_cpu_i.io_write(EBA_OFS_CTRL, 8'h01);
        wait_idle();
        rd(EBA_OFS_ADDR_LOW, 8'h00);
        rd(EBA_OFS_ADDR_HIGH, 8'h00);
        rd(EBA_OFS_DATA, 8'h3c);
        do_read();
        rd(EBA_OFS_DATA, 8'h3c);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule

/* rtl/eba_array.sv */
`timescale 1ns/1ps
module eba_array
    import eba_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [EBA_ADDR_W-1:0] addr,
    input  wire logic                  prog_en,
    input  wire eba_mode_t             mode,
    input  wire logic [7:0]            wr_data,
    output      logic [7:0]            rd_data
);

    // ========================================================================
    // Byte array
    // Left without reset: the content models nonvolatile storage.
    logic [7:0] mem [EBA_DEPTH];
    logic [7:0] prog_value;

    assign rd_data = mem[addr];

    always_comb begin
        case (mode)
            EBA_MODE_ATOMIC: prog_value = wr_data;
            EBA_MODE_ERASE:  prog_value = EBA_ERASED;
            EBA_MODE_WRITE:  prog_value = mem[addr] & wr_data;
            default:         prog_value = mem[addr];
        endcase
    end

    always_ff @(posedge clk) begin
        if (prog_en) begin
            mem[addr] <= prog_value;
        end
    end

endmodule

/* rtl/eba_pkg.sv */
// Overview of operation
// - Provide 512 separate nonvolatile bytes, each readable and writable on its own.
// - Address, data and control registers sit in the processor I/O register space.
// - Writes are timed internally; the strobe bit shows when another byte may go.
// - A write starts only through the armed two-step sequence software must follow.
// - A read stalls the CPU for four clock cycles, two if the same control write also starts a write.
// - Starting a write stalls the CPU for two clock cycles.
// - Byte address is nine bits: bit 8 high register, bits 7..0 low register.
// - Address pair bits 15..9 are read-only and always read zero.
// - Byte addresses 0 to 511 map linearly onto the array.
// - Address content is unspecified after reset; software loads it before any access.
// - Arm bit clears four cycles after set; strobe only starts a write while armed.
// - Write strobe clears itself when the write time has elapsed.
// - During a write, reads are refused and the address cannot change.
// - Mode 00 erase and write, 01 erase only, 10 write only, 11 reserved.
package eba_pkg;

    // ========================================================================
    // I/O register offsets
    localparam logic [5:0] EBA_OFS_CTRL      = 6'h1f;
    localparam logic [5:0] EBA_OFS_DATA      = 6'h20;
    localparam logic [5:0] EBA_OFS_ADDR_LOW  = 6'h21;
    localparam logic [5:0] EBA_OFS_ADDR_HIGH = 6'h22;

    // ========================================================================
    // Control register fields
    localparam int EBA_BIT_READ_STROBE  = 0;
    localparam int EBA_BIT_WRITE_STROBE = 1;
    localparam int EBA_BIT_MASTER_ARM   = 2;
    localparam int EBA_BIT_READY_IE     = 3;
    localparam int EBA_BIT_PROG_MODE_LO = 4;
    localparam int EBA_BIT_PROG_MODE_HI = 5;

    localparam int         EBA_ADDR_W    = 9;
    localparam int         EBA_DEPTH     = 512;
    localparam logic [1:0] EBA_MODE_RST  = 2'h0;
    localparam logic [8:0] EBA_ADDR_RST  = 9'h000;
    localparam logic [7:0] EBA_DATA_RST  = 8'h00;
    localparam logic [7:0] EBA_ERASED    = 8'hff;

    typedef enum logic [1:0] {
        EBA_MODE_ATOMIC = 2'h0,
        EBA_MODE_ERASE  = 2'h1,
        EBA_MODE_WRITE  = 2'h2,
        EBA_MODE_RSVD   = 2'h3
    } eba_mode_t;

    typedef enum logic [1:0] {
        EBA_ST_IDLE = 2'h0,
        EBA_ST_PROG = 2'h1,
        EBA_ST_DONE = 2'h3
    } eba_state_t;

    // ========================================================================
    // Timing
    localparam logic [2:0] EBA_ARM_CYCLES         = 3'h4;
    localparam logic [2:0] EBA_READ_STALL_CYCLES  = 3'h4;
    localparam logic [2:0] EBA_WRITE_STALL_CYCLES = 3'h2;
    // Times are in steps of 100 us and the period in ns, so the products stay inside an int.
    localparam int EBA_CLK_PERIOD_NS     = 4;
    localparam int EBA_ATOMIC_TIME_US100 = 34;
    localparam int EBA_SPLIT_TIME_US100  = 18;
    localparam int EBA_ATOMIC_CYCLES =
        (EBA_ATOMIC_TIME_US100 * 100000 + EBA_CLK_PERIOD_NS - 1) / EBA_CLK_PERIOD_NS;
    localparam int EBA_SPLIT_CYCLES =
        (EBA_SPLIT_TIME_US100 * 100000 + EBA_CLK_PERIOD_NS - 1) / EBA_CLK_PERIOD_NS;
    localparam int EBA_CNT_W = 20;

endpackage

/* rtl/eba_top.sv */
`timescale 1ns/1ps
module eba_top
    import eba_pkg::*;
#(
    parameter int ATOMIC_CYCLES = EBA_ATOMIC_CYCLES,
    parameter int SPLIT_CYCLES  = EBA_SPLIT_CYCLES
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] io_addr,
    input  wire logic       io_we,
    input  wire logic       io_re,
    input  wire logic [7:0] io_wdata,
    output      logic [7:0] io_rdata,
    output      logic       cpu_stall,
    output      logic       busy,
    output      logic       ready_pulse
);

    generate
        if (ATOMIC_CYCLES < 2 || ATOMIC_CYCLES >= (1 << EBA_CNT_W) ||
            SPLIT_CYCLES < 2 || SPLIT_CYCLES >= (1 << EBA_CNT_W)) begin : g_bad
            $error("Write cycle counts do not fit the program counter.");
        end
    endgenerate

    // ========================================================================
    // State
    logic [EBA_ADDR_W-1:0] addr_reg,      addr_next;
    logic [7:0]            data_reg,      data_next;
    logic [7:0]            wdata_reg,     wdata_next;
    eba_mode_t             mode_reg,      mode_next;
    logic                  ie_reg,        ie_next;
    logic                  arm_reg,       arm_next;
    logic [2:0]            arm_cnt_reg,   arm_cnt_next;
    logic                  strobe_reg,    strobe_next;
    logic [2:0]            stall_cnt_reg, stall_cnt_next;
    logic                  stall_reg,     stall_next;
    eba_state_t            state_reg,     state_next;
    logic [EBA_CNT_W-1:0]  prog_cnt_reg,  prog_cnt_next;
    logic                  ready_reg,     ready_next;
    logic [7:0]            rdata_reg,     rdata_next;
    logic [7:0]            array_rd;
    logic                  prog_en;
    logic                  wr_ctrl;
    logic                  read_ok;
    logic                  write_ok;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_ctrl  = io_we && hit(io_addr, EBA_OFS_CTRL);
    // A read while programming would see a half-written cell, so it is dropped.
    assign read_ok  = wr_ctrl && io_wdata[EBA_BIT_READ_STROBE] && !strobe_reg;
    assign write_ok = wr_ctrl && io_wdata[EBA_BIT_WRITE_STROBE] && arm_reg &&
                      !strobe_reg && (mode_reg != EBA_MODE_RSVD);
    assign prog_en  = (state_reg == EBA_ST_DONE);

    eba_array u_array (
        .clk     (clk),
        .addr    (addr_reg),
        .prog_en (prog_en),
        .mode    (mode_reg),
        .wr_data (wdata_reg),
        .rd_data (array_rd)
    );

    // ========================================================================
    // Register file and access sequencing
    always_comb begin
        addr_next      = addr_reg;
        data_next      = data_reg;
        wdata_next     = wdata_reg;
        mode_next      = mode_reg;
        ie_next        = ie_reg;
        arm_next       = arm_reg;
        arm_cnt_next   = arm_cnt_reg;
        strobe_next    = strobe_reg;
        stall_cnt_next = (stall_cnt_reg != 3'h0) ? stall_cnt_reg - 3'h1 : 3'h0;
        state_next     = state_reg;
        prog_cnt_next  = prog_cnt_reg;
        ready_next     = 1'b0;
        rdata_next     = 8'h00;

        // The arm bit lives exactly four cycles, then drops.
        if (arm_cnt_reg != 3'h0) begin
            arm_cnt_next = arm_cnt_reg - 3'h1;
            arm_next     = (arm_cnt_reg != 3'h1);
        end

        if (io_we && !strobe_reg) begin
            if (hit(io_addr, EBA_OFS_ADDR_LOW)) begin
                addr_next[7:0] = io_wdata;
            end
            if (hit(io_addr, EBA_OFS_ADDR_HIGH)) begin
                addr_next[8] = io_wdata[0];
            end
        end
        if (io_we && hit(io_addr, EBA_OFS_DATA)) begin
            data_next = io_wdata;
        end
        if (wr_ctrl) begin
            ie_next = io_wdata[EBA_BIT_READY_IE];
            if (!strobe_reg) begin
                mode_next = eba_mode_t'({io_wdata[EBA_BIT_PROG_MODE_HI],
                                         io_wdata[EBA_BIT_PROG_MODE_LO]});
            end
            if (io_wdata[EBA_BIT_MASTER_ARM] && !write_ok) begin
                arm_next     = 1'b1;
                arm_cnt_next = EBA_ARM_CYCLES;
            end
        end

        if (read_ok) begin
            data_next      = array_rd;
            stall_cnt_next = EBA_READ_STALL_CYCLES;
        end

        case (state_reg)
            EBA_ST_IDLE: begin
                if (write_ok) begin
                    strobe_next    = 1'b1;
                    arm_next       = 1'b0;
                    arm_cnt_next   = 3'h0;
                    wdata_next     = data_reg;
                    stall_cnt_next = EBA_WRITE_STALL_CYCLES;
                    state_next     = EBA_ST_PROG;
                    prog_cnt_next  = (mode_reg == EBA_MODE_ATOMIC) ?
                                     EBA_CNT_W'(ATOMIC_CYCLES - 2) :
                                     EBA_CNT_W'(SPLIT_CYCLES - 2);
                end
            end
            EBA_ST_PROG: begin
                if (prog_cnt_reg == '0) begin
                    state_next = EBA_ST_DONE;
                end else begin
                    prog_cnt_next = prog_cnt_reg - EBA_CNT_W'(1);
                end
            end
            EBA_ST_DONE: begin
                strobe_next = 1'b0;
                ready_next  = 1'b1;
                state_next  = EBA_ST_IDLE;
            end
            default: begin
                state_next  = EBA_ST_IDLE;
                strobe_next = 1'b0;
            end
        endcase

        stall_next = (stall_cnt_next != 3'h0);

        if (io_re) begin
            case (io_addr)
                EBA_OFS_CTRL:      rdata_next = {2'h0, mode_reg, ie_reg, arm_reg,
                                                 strobe_reg, 1'b0};
                EBA_OFS_DATA:      rdata_next = data_reg;
                EBA_OFS_ADDR_LOW:  rdata_next = addr_reg[7:0];
                EBA_OFS_ADDR_HIGH: rdata_next = {7'h00, addr_reg[8]};
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    // Address reset is only for determinism; software must still load it.
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_reg      <= EBA_ADDR_RST;
            data_reg      <= EBA_DATA_RST;
            wdata_reg     <= EBA_DATA_RST;
            mode_reg      <= EBA_MODE_ATOMIC;
            ie_reg        <= 1'b0;
            arm_reg       <= 1'b0;
            arm_cnt_reg   <= 3'h0;
            strobe_reg    <= 1'b0;
            stall_cnt_reg <= 3'h0;
            stall_reg     <= 1'b0;
            state_reg     <= EBA_ST_IDLE;
            prog_cnt_reg  <= '0;
            ready_reg     <= 1'b0;
            rdata_reg     <= 8'h00;
        end else begin
            addr_reg      <= addr_next;
            data_reg      <= data_next;
            wdata_reg     <= wdata_next;
            mode_reg      <= mode_next;
            ie_reg        <= ie_next;
            arm_reg       <= arm_next;
            arm_cnt_reg   <= arm_cnt_next;
            strobe_reg    <= strobe_next;
            stall_cnt_reg <= stall_cnt_next;
            stall_reg     <= stall_next;
            state_reg     <= state_next;
            prog_cnt_reg  <= prog_cnt_next;
            ready_reg     <= ready_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign io_rdata    = rdata_reg;
    assign cpu_stall   = stall_reg;
    assign busy        = strobe_reg;
    assign ready_pulse = ready_reg;

    // ========================================================================
    // Check helpers
    // Counts busy cycles so the full write length can be checked without long repetitions.
    logic [EBA_CNT_W-1:0] busy_len_reg, busy_len_next;
    logic [EBA_CNT_W-1:0] busy_len_exp;

    always_comb begin
        busy_len_next = busy ? busy_len_reg + EBA_CNT_W'(1) : '0;
        busy_len_exp  = (mode_reg == EBA_MODE_ATOMIC) ? EBA_CNT_W'(ATOMIC_CYCLES) :
                                                        EBA_CNT_W'(SPLIT_CYCLES);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_len_reg <= '0;
        end else begin
            busy_len_reg <= busy_len_next;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    stall_read_a: assert property (read_ok |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("Read stall is not four cycles.");
    stall_write_a: assert property (write_ok |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("Write stall is not two cycles.");
    // Any control write inside the window may re-arm or consume it, so only quiet ones count.
    arm_life_a: assert property (($rose(arm_reg) && !wr_ctrl) ##1 !wr_ctrl [*3]
                                 |-> arm_reg && $past(arm_reg) && $past(arm_reg, 2)
                                 ##1 !arm_reg)
        else $error("Arm bit lifetime wrong.");
    arm_used_a: assert property ($rose(busy) |-> !arm_reg)
        else $error("Arm bit survived a write start.");
    no_arm_a: assert property (!busy && !arm_reg && wr_ctrl |=> !busy)
        else $error("Write started while not armed.");
    rsvd_mode_a: assert property (!busy && wr_ctrl && mode_reg == EBA_MODE_RSVD |=> !busy)
        else $error("Reserved mode started a write.");
    start_armed_a: assert property ($rose(busy) |-> $past(arm_reg))
        else $error("Write started without arm.");
    addr_hold_a: assert property (busy && $past(busy) |-> $stable(addr_reg))
        else $error("Address changed during write.");
    mode_hold_a: assert property (busy && $past(busy) |-> $stable(mode_reg))
        else $error("Mode changed during write.");
    high_zero_a: assert property (io_re && io_addr == EBA_OFS_ADDR_HIGH
                                  |=> io_rdata[7:1] == 7'h00)
        else $error("High address upper bits not zero.");
    ready_end_a: assert property ($fell(busy) |-> ready_pulse ##1 !ready_pulse)
        else $error("Ready pulse missing at write end.");
    busy_span_a: assert property ($rose(busy) |-> busy [*8])
        else $error("Write ended too early.");
    no_read_a: assert property (busy && wr_ctrl && io_wdata[EBA_BIT_READ_STROBE]
                                |=> $stable(data_reg))
        else $error("Read accepted during write.");
    read_data_a: assert property (read_ok |=> data_reg == $past(array_rd))
        else $error("Read data not taken from the array.");
    rdata_idle_a: assert property (!io_re |=> io_rdata == 8'h00)
        else $error("Read data not cleared.");
    ready_only_a: assert property (ready_pulse |-> !busy && $past(busy))
        else $error("Ready pulse outside a write end.");
    write_len_a: assert property ($fell(busy) |-> busy_len_reg == busy_len_exp)
        else $error("Write length does not match its mode.");

    read_c: cover property (read_ok);
    write_c: cover property (write_ok);
    done_c: cover property (ready_pulse);
    lapse_c: cover property ($fell(arm_reg) && !busy);
    rsvd_c: cover property (wr_ctrl && io_wdata[EBA_BIT_WRITE_STROBE] && arm_reg &&
                            mode_reg == EBA_MODE_RSVD);

endmodule
